/* File: verilog/apc_pkg.sv */
// Shared constants and types for the parallel conversion port.
package apc_pkg;
  localparam int RES_W = 12;
  localparam int CH_W = 2;
  localparam int CONV_CYCLES = 12;
  localparam int CLK_PER_SAMPLE = 16;
  localparam logic [RES_W-1:0] RESULT_ZERO = 12'h000;
  localparam logic [RES_W-1:0] RESULT_FULL = 12'hfff;
  localparam logic [3:0] BIT_MSB_IDX = 4'hb;
  typedef enum logic [1:0] {APC_IDLE, APC_ARM, APC_CONV} apc_state_t;
endpackage

/* File: verilog/apc_sar_if.sv */
// Interface between the port control and the bit-decision engine.
`timescale 1ns/1ps
interface apc_sar_if;
  logic start;
  logic step;
  logic [11:0] sample;
  logic [11:0] result;
  logic done;
  modport ctrl (output start, output step, output sample, input result, input done);
  modport sar (input start, input step, input sample, output result, output done);
endinterface

/* File: verilog/apc_sar.sv */
// Successive approximation engine: one result bit per conversion clock, MSB first.
`timescale 1ns/1ps
module apc_sar (
  input wire logic clk_sys,
  input wire logic srst,
  apc_sar_if.sar sif
);
  logic [11:0] trial_r;
  logic [11:0] acc_r;
  logic [3:0] idx_r;
  logic busy_r;
  logic done_r;
  logic [11:0] guess;
  logic keep;
  // Comparator against the held sample stands in for the analog CDAC.
  assign guess = acc_r | trial_r;
  assign keep = (guess <= sif.sample);
  assign sif.result = acc_r;
  assign sif.done = done_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trial_r <= 12'h000;
      acc_r <= apc_pkg::RESULT_ZERO;
      idx_r <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (sif.start) begin
        trial_r <= 12'h800;
        acc_r <= apc_pkg::RESULT_ZERO;
        idx_r <= apc_pkg::BIT_MSB_IDX;
        busy_r <= 1'b1;
      end else if (busy_r && sif.step) begin
        if (keep) begin
          acc_r <= guess;
        end
        trial_r <= trial_r >> 1;
        if (idx_r == 4'h0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          idx_r <= idx_r - 4'h1;
        end
      end
    end
  end
endmodule

/* File: verilog/apc_port.sv */
// Host-facing control of the four-channel converter: strobes, busy, result bus.
//
// Function
// - Chip select plus write low starts conversion.
// - Write with chip select floats result outputs.
// - Write cycle picks channel from address lines.
// - Result driven only while read and select low.
// - Busy goes low for whole conversion.
// - Busy rises at completion; results then readable.
// - Address latched on read or write rising.
// - Address pairs select inputs zero to three.
// - Start on clock edge, twelve bits MSB first.
// - Results are straight binary, zero to full.
// - Read rise with address low bit powers down/up.
`timescale 1ns/1ps
module apc_port (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic channel_addr_lo,
  input wire logic channel_addr_hi,
  input wire logic conv_clk,
  input wire logic [11:0] analog_input_0,
  input wire logic [11:0] analog_input_1,
  input wire logic [11:0] analog_input_2,
  input wire logic [11:0] analog_input_3,
  output logic busy_n,
  output logic [11:0] result_o,
  output logic [11:0] result_oe_n,
  output logic power_down,
  output logic [1:0] channel_sel
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic cs_s;
  logic wr_s;
  logic rd_s;
  logic addr_lo_s;
  logic addr_hi_s;
  logic ck_s;
  always_ff @(posedge clk_sys) begin
    pin_s1_r <= {conv_clk, channel_addr_hi, channel_addr_lo, rd_n, wr_n, cs_n};
    pin_s2_r <= pin_s1_r;
  end
  assign {ck_s, addr_hi_s, addr_lo_s, rd_s, wr_s, cs_s} = pin_s2_r;

  // ==========================================================
  // Edge detection on synchronised strobes
  // ==========================================================
  logic wr_d_r;
  logic rd_d_r;
  logic ck_d_r;
  logic wr_fall;
  logic wr_rise;
  logic rd_rise;
  logic ck_rise;
  logic wr_sel;
  logic rd_sel;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
      ck_d_r <= 1'b0;
    end else begin
      wr_d_r <= wr_s;
      rd_d_r <= rd_s;
      ck_d_r <= ck_s;
    end
  end
  assign wr_fall = wr_d_r && !wr_s;
  assign wr_rise = !wr_d_r && wr_s;
  assign rd_rise = !rd_d_r && rd_s;
  assign ck_rise = !ck_d_r && ck_s;
  assign wr_sel = !cs_s && !wr_s;
  assign rd_sel = !cs_s && !rd_s;

  // ==========================================================
  // Channel address latch and input selection
  // ==========================================================
  logic [1:0] chan_r;
  logic [1:0] addr_now;
  logic [11:0] picked;
  // The low address line is the upper index bit, so lo=0, hi=1 selects input 1.
  assign addr_now = {addr_lo_s, addr_hi_s};
  always_comb begin
    unique case (chan_r)
      2'b00: picked = analog_input_0;
      2'b01: picked = analog_input_1;
      2'b10: picked = analog_input_2;
      2'b11: picked = analog_input_3;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan_r <= 2'b00;
    end else if (!cs_s && (wr_rise || rd_rise)) begin
      chan_r <= addr_now;
    end else if (wr_sel && wr_fall) begin
      chan_r <= addr_now;
    end
  end

  // ==========================================================
  // Conversion sequencing
  // ==========================================================
  apc_sar_if sif ();
  apc_sar u_sar (
    .clk_sys(clk_sys),
    .srst(srst),
    .sif(sif)
  );
  apc_pkg::apc_state_t state_r;
  apc_pkg::apc_state_t state_nxt;
  logic [11:0] sample_r;
  logic [11:0] data_r;
  logic pd_r;
  logic start_pend_r;
  // A write may fall mid-conversion; the conversion restarts on the next clock edge.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      apc_pkg::APC_IDLE: if (start_pend_r) state_nxt = apc_pkg::APC_ARM;
      apc_pkg::APC_ARM: if (ck_rise) state_nxt = apc_pkg::APC_CONV;
      apc_pkg::APC_CONV: begin
        if (start_pend_r) state_nxt = apc_pkg::APC_ARM;
        else if (sif.done) state_nxt = apc_pkg::APC_IDLE;
      end
    endcase
  end
  assign sif.start = (state_r == apc_pkg::APC_ARM) && ck_rise;
  assign sif.step = (state_r == apc_pkg::APC_CONV) && ck_rise && !start_pend_r;
  assign sif.sample = sample_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= apc_pkg::APC_IDLE;
      start_pend_r <= 1'b0;
      sample_r <= apc_pkg::RESULT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (wr_sel && wr_fall) begin
        start_pend_r <= 1'b1;
      end else if (state_r == apc_pkg::APC_ARM || state_r == apc_pkg::APC_IDLE) begin
        start_pend_r <= 1'b0;
      end
      if (sif.start) begin
        sample_r <= picked;
      end
    end
  end

  // ==========================================================
  // Result hold, busy, power-down and output drivers
  // ==========================================================
  logic converting;
  logic drive_en;
  assign converting = start_pend_r || state_r != apc_pkg::APC_IDLE;
  // Drive only for a read, never while a write is selected or a conversion runs.
  assign drive_en = rd_sel && !wr_sel && !converting && !pd_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_r <= apc_pkg::RESULT_ZERO;
      pd_r <= 1'b0;
      busy_n <= 1'b1;
      result_o <= apc_pkg::RESULT_ZERO;
      result_oe_n <= 12'hfff;
      power_down <= 1'b0;
      channel_sel <= 2'b00;
    end else begin
      if (sif.done && !start_pend_r) begin
        data_r <= sif.result;
      end
      if (!cs_s && rd_rise && !converting) begin
        pd_r <= addr_lo_s;
      end
      busy_n <= !(converting || (wr_sel && wr_fall));
      result_o <= data_r;
      result_oe_n <= drive_en ? 12'h000 : 12'hfff;
      power_down <= pd_r;
      channel_sel <= chan_r;
    end
  end
endmodule

/* File: verification/apc_host_clk.sv */
// Host-side conversion clock source for the converter port.
`timescale 1ns/1ps
module apc_host_clk #(parameter int HALF = 8) (
  input wire logic clk_sys,
  output logic conv_clk
);
  int cnt_r = 0;
  initial conv_clk = 1'b0;
  // Free running; eight system cycles a phase stays above the port's sampling limit.
  always @(posedge clk_sys) begin
    cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
    if (cnt_r == HALF - 1) conv_clk <= ~conv_clk;
  end
endmodule

/* File: verification/apc_port_sva.sv */
// Concurrent checks on the converter port pins.
`timescale 1ns/1ps
module apc_port_sva (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic channel_addr_lo,
  input wire logic channel_addr_hi,
  input wire logic conv_clk,
  input wire logic [11:0] analog_input_0,
  input wire logic [11:0] analog_input_1,
  input wire logic [11:0] analog_input_2,
  input wire logic [11:0] analog_input_3,
  input wire logic busy_n,
  input wire logic [11:0] result_o,
  input wire logic [11:0] result_oe_n,
  input wire logic power_down,
  input wire logic [1:0] channel_sel
);
  logic [7:0] wr_age_r;
  logic [4:0] rise_cnt_r;
  logic conv_d_r;
  wire conv_rise = conv_clk && !conv_d_r;
  wire [11:0] sel_lo = channel_sel[0] ? analog_input_1 : analog_input_0;
  wire [11:0] sel_hi = channel_sel[0] ? analog_input_3 : analog_input_2;
  wire [11:0] sel_in = channel_sel[1] ? sel_hi : sel_lo;
  // Age saturates so a long idle spell never wraps back into the start window.
  always_ff @(posedge clk_sys) begin
    conv_d_r <= conv_clk;
    wr_age_r <= srst ? 8'hff : (!cs_n && !wr_n) ? 8'h00 : wr_age_r + {7'h0, wr_age_r != 8'hff};
    rise_cnt_r <= busy_n ? 5'h00 : rise_cnt_r + {4'h0, conv_rise};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_write_floats_bus: assert property ((!cs_n && !wr_n) [*6] |-> result_oe_n == 12'hfff) else $error("bus driven");
  a_idle_bus_floats: assert property ((cs_n || rd_n) [*6] |-> result_oe_n == 12'hfff) else $error("bus driven");
  // The output enable trails the pins by two synchroniser stages and its own register.
  a_drive_needs_read: assert property (result_oe_n != 12'hfff |->
    result_oe_n == 12'h000 && busy_n && !power_down && $past(rd_n, 3) == 1'b0 && $past(cs_n, 3) == 1'b0)
    else $error("bad drive");
  a_busy_from_write: assert property ($fell(busy_n) |-> wr_age_r <= 8'h06) else $error("busy cause");
  a_busy_holds: assert property ($fell(busy_n) |=> !busy_n [*8]) else $error("busy short");
  a_twelve_bits: assert property ($rose(busy_n) |-> rise_cnt_r inside {[12:14]}) else $error("bit count");
  a_channel_latch: assert property ($fell(busy_n) |->
    ##[0:3] channel_sel == {channel_addr_lo, channel_addr_hi}) else $error("channel");
  a_result_input: assert property ($rose(busy_n) |-> ##[0:2] result_o == sel_in) else $error("result");
  a_pd_when_idle: assert property ($changed(power_down) |-> busy_n && !cs_n) else $error("power state");
endmodule
bind apc_port apc_port_sva chk (
  .clk_sys(clk_sys),
  .srst(srst),
  .cs_n(cs_n),
  .wr_n(wr_n),
  .rd_n(rd_n),
  .channel_addr_lo(channel_addr_lo),
  .channel_addr_hi(channel_addr_hi),
  .conv_clk(conv_clk),
  .analog_input_0(analog_input_0),
  .analog_input_1(analog_input_1),
  .analog_input_2(analog_input_2),
  .analog_input_3(analog_input_3),
  .busy_n(busy_n),
  .result_o(result_o),
  .result_oe_n(result_oe_n),
  .power_down(power_down),
  .channel_sel(channel_sel)
);

/* File: verification/tb_top.sv */
// Self-checking bench for the parallel conversion port.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, srst = 1'b1, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, conv_clk;
  logic channel_addr_lo = 1'b0, channel_addr_hi = 1'b0, busy_n, power_down;
  logic [11:0] analog_input_0 = 12'h000, analog_input_1 = 12'h5a3, analog_input_2 = 12'hc3c;
  logic [11:0] analog_input_3 = 12'hfff, result_o, result_oe_n;
  logic [1:0] channel_sel;
  int bad_count = 0, n_tests = 0, cyc = 0;
  wire [47:0] all_in = {analog_input_3, analog_input_2, analog_input_1, analog_input_0};
  always #2.5 clk_sys = ~clk_sys;
  apc_port DUT (
    .clk_sys(clk_sys),
    .srst(srst),
    .cs_n(cs_n),
    .wr_n(wr_n),
    .rd_n(rd_n),
    .channel_addr_lo(channel_addr_lo),
    .channel_addr_hi(channel_addr_hi),
    .conv_clk(conv_clk),
    .analog_input_0(analog_input_0),
    .analog_input_1(analog_input_1),
    .analog_input_2(analog_input_2),
    .analog_input_3(analog_input_3),
    .busy_n(busy_n),
    .result_o(result_o),
    .result_oe_n(result_oe_n),
    .power_down(power_down),
    .channel_sel(channel_sel)
  );
  apc_host_clk host (.clk_sys(clk_sys), .conv_clk(conv_clk));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Read cycle; the rising read strobe carries the power state in the low address line.
  task automatic read_back(input logic lo, input logic [11:0] exp_oe, input logic exp_pd);
    {cs_n, rd_n} = 2'b00;
    idle(8);
    chk(result_oe_n, exp_oe);
    channel_addr_lo = lo;
    rd_n = 1'b1;
    idle(8);
    chk(result_oe_n, 12'hfff);
    chk({11'h0, power_down}, {11'h0, exp_pd});
    cs_n = 1'b1;
    idle(1);
  endtask
  task automatic convert(input logic [1:0] ch, input logic early);
    int k;
    {channel_addr_lo, channel_addr_hi} = ch;
    {cs_n, wr_n} = 2'b00;
    idle(8);
    chk({11'h0, busy_n}, 12'h000);
    chk(result_oe_n, 12'hfff);
    {cs_n, wr_n} = 2'b11;
    idle(1);
    // A read rise latches the address, so the early read keeps the low line where the write put it.
    if (early) read_back(ch[1], 12'hfff, 1'b0);
    for (k = 0; k < 600 && busy_n !== 1'b1; k++) idle(1);
    idle(3);
    chk({11'h0, busy_n}, 12'h001);
    chk({10'h0, channel_sel}, {10'h0, ch});
    chk(result_o, all_in[12 * ch +: 12]);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    idle(12);
    srst = 1'b0;
    chk(result_oe_n, 12'hfff);
    chk({result_o[9:0], busy_n, power_down}, 12'h002);
    idle(3);
    for (int c = 0; c < 4; c++) begin
      convert(c[1:0], c == 2);
      read_back(1'b0, 12'h000, 1'b0);
    end
    convert(2'd1, 1'b0);
    read_back(1'b1, 12'h000, 1'b1);
    chk({10'h0, channel_sel}, 12'h003);
    read_back(1'b0, 12'hfff, 1'b0);
    tally_and_finish;
  end
endmodule
